// File: verilog/snoop_flow_regs.vh
// Constants for the uncore coherence and snoop flow block.
// Assumes inclusion by bare name from files under verilog/.
`ifndef SNOOP_FLOW_REGS_VH
`define SNOOP_FLOW_REGS_VH

// Register byte offsets on the APB
`define REG_CTRL        12'h000
`define REG_EVSEL       12'h004
`define REG_MATCH_LO    12'h008
`define REG_MATCH_HI    12'h00C
`define REG_COUNT       12'h010
`define REG_STATUS      12'h014
`define REG_HOMEBIT     12'h018

// Control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_CLEAR_BIT  1

// Event selection codes
`define EV_SNP_LOCAL    8'h06
`define EV_SNP_REMOTE   8'h07
`define EV_LLC_HIT      8'h08
`define EV_LLC_MISS     8'h09
`define EV_LINES_IN     8'h0A
`define EV_LINES_OUT    8'h0B
`define EV_OPC_MATCH    8'h35

// Unit mask source selects for opcode matching
`define UMASK_IO_HUB    4'h1
`define UMASK_REMOTE    4'h2
`define UMASK_LOCAL     4'h4

// Predefined match values, upper word (lower word zero)
`define MATCH_FWD_INV   32'h4000_1900
`define MATCH_FWD_SHR   32'h4000_1A00
`define MATCH_INV_WB    32'h4000_1D00

// Tracker sizing
`define PPT_ENTRIES     12
`define PPT_IDX_W       4

// Line states
`define ST_I            2'h0
`define ST_S            2'h1
`define ST_F            2'h2
`define ST_M            2'h3

// Reset values
`define CTRL_RESET      32'h0000_0000
`define EVSEL_RESET     32'h0000_0000
`define HOMEBIT_RESET   32'h0000_0000

`endif

// File: verilog/coherence_snoop_flow.v
// Global request queue flow: core requests, peer snoops, home logic completion
// and a performance counter reached over APB.
// Assumes synchronous single-cycle request strobes and one clock, pclk.
//
// Overview of operation
// [R1] Core request first looks up last-level cache
// [R2] Sole-owner hit returns data without snooping
// [R3] Shared hit snoops cores, updates cache, forwards
// [R4] Miss: home from address, local or link
// [R5] Link request when remote copy possible
// [R6] Peer snoop responses occupy probe tracker entry
// [R7] Peer probe tracker holds twelve entries
// [R8] Snoop responses classed local or remote home
// [R9] Modified line read snoop also writes back
// [R10] Ownership snoop on modified skips writeback
// [R11] Snoop responses counted under 06H and 07H
// [R12] Shared match register events one at a time
// [R13] Cache hit and miss under 08H, 09H
// [R14] Lines in and out under 0AH, 0BH
// [R15] Local-home miss goes to home and link
// [R16] Remote data first supersedes home logic request
// [R17] Remote modified read data written back
// [R18] Local snoop hit signals home logic completion
// [R19] Modified load snoop: writeback then forward
// [R20] Opcode match 35H with match register, umask
// [R21] Predefined match values select response types
// [R22] Read finding modified line comes from home
// [R23] Ownership snoop on shared invalidates, home supplies
// [R24] First valid response wins, later duplicate dropped
`include "snoop_flow_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module coherence_snoop_flow
(
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Core request and last-level cache lookup result
  input  wire        core_req,
  input  wire        core_req_rfo,
  input  wire [39:0] core_req_addr,
  input  wire        llc_hit,
  input  wire        llc_sole_owner,
  input  wire        core_snoop_hitm,
  // Remote and home responses for the outstanding miss
  input  wire        remote_data_valid,
  input  wire        remote_data_mod,
  input  wire        home_data_valid,
  // Incoming peer snoop
  input  wire        peer_snoop,
  input  wire        peer_snoop_rfo,
  input  wire        peer_snoop_local,
  input  wire        peer_snoop_from_io,
  input  wire [1:0]  peer_line_state,
  input  wire        peer_snoop_done,
  // Actions toward cores, cache, home logic and link
  output reg         llc_data_return,
  output reg         core_snoop_issue,
  output reg         llc_update,
  output reg         forward_to_core,
  output reg         home_req,
  output reg         link_req,
  output reg         home_complete,
  output reg         mem_writeback,
  output reg         link_forward,
  output reg         line_invalidate,
  output reg         tracker_full
);

  // ----------------------------------------------------------------
  // Request flow state machine
  // ----------------------------------------------------------------
  localparam [4:0] S_IDLE   = 5'b00001;
  localparam [4:0] S_LOOKUP = 5'b00010;
  localparam [4:0] S_SNOOP  = 5'b00100;
  localparam [4:0] S_MISS   = 5'b01000;
  localparam [4:0] S_DONE   = 5'b10000;

  reg [4:0]  state_q;
  reg        req_rfo_q;
  reg        req_local_q;
  reg        served_q;
  reg [31:0] ctrl_q;
  reg [31:0] evsel_q;
  reg [31:0] match_lo_q;
  reg [31:0] match_hi_q;
  reg [31:0] count_q;
  reg [31:0] homebit_q;
  reg [`PPT_ENTRIES-1:0] ppt_q;
  reg        ev_snp_local_q;
  reg        ev_snp_remote_q;
  reg        ev_hit_q;
  reg        ev_miss_q;
  reg        ev_in_q;
  reg        ev_out_q;
  reg        ev_match_q;

  wire [5:0] home_sel = homebit_q[5:0];
  // Home socket bit picked out of the physical address by software
  wire       addr_local = (core_req_addr[home_sel] == 1'b0);

  // Main flow; outputs default low so every action is a one-cycle pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q         <= S_IDLE;
      req_rfo_q       <= 1'b0;
      req_local_q     <= 1'b0;
      served_q        <= 1'b0;
      llc_data_return <= 1'b0;
      core_snoop_issue<= 1'b0;
      llc_update      <= 1'b0;
      forward_to_core <= 1'b0;
      home_req        <= 1'b0;
      link_req        <= 1'b0;
      ev_hit_q        <= 1'b0;
      ev_miss_q       <= 1'b0;
      ev_in_q         <= 1'b0;
      ev_out_q        <= 1'b0;
    end
    else if (clk_en)
    begin
      llc_data_return <= 1'b0;
      core_snoop_issue<= 1'b0;
      llc_update      <= 1'b0;
      forward_to_core <= 1'b0;
      home_req        <= 1'b0;
      link_req        <= 1'b0;
      ev_hit_q        <= 1'b0;
      ev_miss_q       <= 1'b0;
      ev_in_q         <= 1'b0;
      ev_out_q        <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (core_req)
          begin
            req_rfo_q   <= core_req_rfo;
            req_local_q <= addr_local;
            state_q     <= S_LOOKUP; // see [R1]
          end
        end
        S_LOOKUP:
        begin
          // Inclusive cache: this lookup alone settles package presence
          if (llc_hit)
          begin
            ev_hit_q <= 1'b1; // see [R13]
            if (llc_sole_owner)
            begin
              llc_data_return <= 1'b1; // see [R2]
              state_q         <= S_IDLE;
            end
            else
            begin
              core_snoop_issue <= 1'b1; // see [R3]
              state_q          <= S_SNOOP;
            end
          end
          else
          begin
            ev_miss_q <= 1'b1; // see [R13]
            // Local home: home logic and link at once; remote: link only
            home_req  <= req_local_q; // see [R4] see [R15]
            link_req  <= 1'b1;        // see [R5]
            served_q  <= 1'b0;
            state_q   <= S_MISS;
          end
        end
        S_SNOOP:
        begin
          // One cycle later the sibling snoop result is sampled
          llc_update      <= core_snoop_hitm; // see [R3]
          forward_to_core <= 1'b1;
          state_q         <= S_IDLE;
        end
        S_MISS:
        begin
          // First valid data fills; the cache takes the line in
          if (remote_data_valid || home_data_valid)
          begin
            forward_to_core <= 1'b1; // see [R24]
            ev_in_q         <= 1'b1; // see [R14]
            ev_out_q        <= 1'b1;
            served_q        <= 1'b1;
            state_q         <= S_DONE;
          end
        end
        S_DONE:
        begin
          // Later duplicate responses are dropped here
          state_q <= S_IDLE; // see [R24]
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Home logic completion, writebacks and peer snoop answers
  // ----------------------------------------------------------------
  reg [`PPT_ENTRIES-1:0] ppt_alloc;
  reg [`PPT_ENTRIES-1:0] ppt_free;
  integer i;

  // Lowest free tracker slot for a new peer snoop, lowest busy to retire
  always @*
  begin
    ppt_alloc = {`PPT_ENTRIES{1'b0}};
    ppt_free  = {`PPT_ENTRIES{1'b0}};
    for (i = `PPT_ENTRIES - 1; i >= 0; i = i - 1)
    begin
      if (!ppt_q[i])
      begin
        ppt_alloc = {`PPT_ENTRIES{1'b0}};
        ppt_alloc[i] = 1'b1;
      end
      else
      begin
        ppt_free = {`PPT_ENTRIES{1'b0}};
        ppt_free[i] = 1'b1;
      end
    end
  end

  wire snoop_take = peer_snoop && !(&ppt_q);
  wire snoop_mod  = (peer_line_state == `ST_M);
  wire snoop_shf  = (peer_line_state == `ST_S) || (peer_line_state == `ST_F);
  reg  snoop_wb_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ppt_q           <= {`PPT_ENTRIES{1'b0}};
      home_complete   <= 1'b0;
      mem_writeback   <= 1'b0;
      link_forward    <= 1'b0;
      snoop_wb_q      <= 1'b0;
      line_invalidate <= 1'b0;
      tracker_full    <= 1'b0;
      ev_snp_local_q  <= 1'b0;
      ev_snp_remote_q <= 1'b0;
      ev_match_q      <= 1'b0;
    end
    else if (clk_en)
    begin
      // A retire and an allocation of the same cycle both take effect; when full, the snoop is refused
      ppt_q <= (ppt_q & ~(peer_snoop_done ? ppt_free : {`PPT_ENTRIES{1'b0}}))
               | (snoop_take ? ppt_alloc : {`PPT_ENTRIES{1'b0}}); // see [R6] see [R7]
      tracker_full <= &ppt_q;
      // Remote caching agent beat the home logic: supersede it
      home_complete   <= (state_q == S_MISS && remote_data_valid && req_local_q && !served_q) // see [R16]
                         || (snoop_take && peer_snoop_local && peer_line_state != `ST_I); // see [R18]
      // Remote modified read data, modified read snoop, read finding modified
      mem_writeback   <= (state_q == S_MISS && remote_data_valid && remote_data_mod && !req_rfo_q) // see [R17] see [R22]
                         || (snoop_take && snoop_mod && !peer_snoop_rfo); // see [R9] see [R10] see [R19]
      // Only a snoop writeback is forwarded over the link; a fill writeback is not
      snoop_wb_q      <= snoop_take && snoop_mod && !peer_snoop_rfo;
      link_forward    <= snoop_wb_q; // see [R19]
      line_invalidate <= snoop_take && peer_snoop_rfo && (snoop_shf || snoop_mod); // see [R23]
      ev_snp_local_q  <= snoop_take && peer_snoop_local;  // see [R8]
      ev_snp_remote_q <= snoop_take && !peer_snoop_local; // see [R8]
      // Opcode match: match register response type and source umask
      ev_match_q <= snoop_take && (match_hi_q != 32'h0000_0000)
                    && ((match_hi_q == `MATCH_INV_WB && snoop_mod && !peer_snoop_rfo)
                     || (match_hi_q == `MATCH_FWD_INV && peer_snoop_rfo)
                     || (match_hi_q == `MATCH_FWD_SHR && snoop_shf && !peer_snoop_rfo))
                    && ((evsel_q[8] && peer_snoop_from_io)
                     || (evsel_q[9] && !peer_snoop_from_io && !peer_snoop_local)
                     || (evsel_q[10] && !peer_snoop_from_io && peer_snoop_local)); // see [R20] see [R21]
    end
  end

  // ----------------------------------------------------------------
  // Single performance counter and its event selection
  // ----------------------------------------------------------------
  reg ev_sel_hit;

  // One counter only, so match-register events are measured one at a time
  always @*
  begin
    case (evsel_q[7:0])
      `EV_SNP_LOCAL:  ev_sel_hit = ev_snp_local_q;  // see [R11]
      `EV_SNP_REMOTE: ev_sel_hit = ev_snp_remote_q; // see [R11]
      `EV_LLC_HIT:    ev_sel_hit = ev_hit_q;        // see [R13]
      `EV_LLC_MISS:   ev_sel_hit = ev_miss_q;       // see [R13]
      `EV_LINES_IN:   ev_sel_hit = ev_in_q;         // see [R14]
      `EV_LINES_OUT:  ev_sel_hit = ev_out_q;        // see [R14]
      `EV_OPC_MATCH:  ev_sel_hit = ev_match_q;      // see [R12] see [R20]
      default:        ev_sel_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait states, unmapped reads zero with pslverr
  // ----------------------------------------------------------------
  wire apb_setup = psel && !penable;
  wire apb_wr    = psel && penable && pwrite && pready;
  reg  [31:0] rd_mux;
  reg         rd_err;

  always @*
  begin
    rd_err = 1'b0;
    case (paddr)
      `REG_CTRL:     rd_mux = ctrl_q;
      `REG_EVSEL:    rd_mux = evsel_q;
      `REG_MATCH_LO: rd_mux = match_lo_q;
      `REG_MATCH_HI: rd_mux = match_hi_q;
      `REG_COUNT:    rd_mux = count_q;
      `REG_STATUS:   rd_mux = {16'h0000, 4'h0, ppt_q};
      `REG_HOMEBIT:  rd_mux = homebit_q;
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  // Access phase answers in its first cycle; data is registered in setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      ctrl_q     <= `CTRL_RESET;
      evsel_q    <= `EVSEL_RESET;
      match_lo_q <= 32'h0000_0000;
      match_hi_q <= 32'h0000_0000;
      homebit_q  <= `HOMEBIT_RESET;
      count_q    <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup && rd_err;
      prdata  <= apb_setup && !pwrite ? rd_mux : 32'h0000_0000;
      if (apb_wr && !pslverr)
      begin
        case (paddr)
          `REG_CTRL:     ctrl_q     <= pwdata;
          `REG_EVSEL:    evsel_q    <= pwdata;
          `REG_MATCH_LO: match_lo_q <= pwdata;
          `REG_MATCH_HI: match_hi_q <= pwdata;
          `REG_HOMEBIT:  homebit_q  <= {26'h000_0000, pwdata[5:0]};
          default:       ctrl_q     <= ctrl_q;
        endcase
      end
      // Clear bit empties the counter; an event in that cycle is lost
      if (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_CLEAR_BIT])
        count_q <= 32'h0000_0000;
      else if (ctrl_q[`CTRL_ENABLE_BIT] && ev_sel_hit)
        count_q <= count_q + 32'h0000_0001;
    end
  end

endmodule

`default_nettype wire

// File: tb/snoop_flow_sva.sv
// Assertions on the ports of the snoop flow block.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "snoop_flow_regs.vh"
module snoop_flow_sva (
  // Clock, reset and inputs
  input wire logic       pclk, presetn, clk_en, llc_hit, llc_sole_owner, peer_snoop, peer_snoop_rfo, peer_snoop_local,
  input wire logic [1:0] peer_line_state,
  // Actions of the block
  input wire logic       tracker_full, llc_data_return, core_snoop_issue, llc_update, forward_to_core,
  input wire logic       home_req, link_req, home_complete, mem_writeback, link_forward, line_invalidate
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Snoop taken; full level lags, so the bench spaces snoops apart; frozen cycles take none
  wire logic acc = peer_snoop && !tracker_full && clk_en;
  sole_hit_a: assert property (llc_data_return |-> $past(llc_hit && llc_sole_owner))
    else $error("data return without sole hit");
  shared_snoop_a: assert property (core_snoop_issue |-> $past(llc_hit && !llc_sole_owner))
    else $error("core snoop without shared hit");
  shared_fwd_a: assert property (core_snoop_issue |-> ##[1:2] forward_to_core)
    else $error("shared hit not forwarded");
  miss_route_a: assert property (link_req |-> $past(!llc_hit))
    else $error("link request without miss");
  home_link_a: assert property (home_req |-> link_req)
    else $error("local miss not sent to link too");
  wb_value_a: assert property (acc |=> mem_writeback ==
    ($past(peer_line_state) == `ST_M && !$past(peer_snoop_rfo)))
    else $error("snoop writeback wrong");
  snoop_inval_a: assert property (acc |=> line_invalidate ==
    ($past(peer_snoop_rfo) && $past(peer_line_state) != `ST_I))
    else $error("snoop invalidate wrong");
  home_done_a: assert property (acc |=> home_complete ==
    ($past(peer_snoop_local) && $past(peer_line_state) != `ST_I))
    else $error("snoop completion wrong");
  wb_fwd_a: assert property (mem_writeback && $past(acc) |=> link_forward)
    else $error("no forward after snoop writeback");
  fwd_source_a: assert property (link_forward |-> $past(mem_writeback && !forward_to_core))
    else $error("link forward without snoop writeback");
  full_refuse_a: assert property (peer_snoop && tracker_full |=> !home_complete && !line_invalidate)
    else $error("snoop taken while full");
  cover property (home_complete && forward_to_core);
  cover property (llc_update);
  cover property (peer_snoop && tracker_full);
endmodule
bind coherence_snoop_flow snoop_flow_sva u_snoop_flow_sva (
  .pclk, .presetn, .llc_hit, .llc_sole_owner, .peer_snoop, .peer_snoop_rfo, .peer_snoop_local, .peer_line_state,
  .tracker_full, .llc_data_return, .core_snoop_issue, .llc_update, .forward_to_core, .home_req, .link_req,
  .home_complete, .mem_writeback, .link_forward, .line_invalidate, .clk_en
);
`default_nettype wire

// File: tb/far_side_model.sv
// Behavioural cores, cache lookup, home logic and remote agent.
// Assumes the bench sets cfg before each core request.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  // Clock and reset
  input  wire logic        pclk, presetn,
  // [9] hit [8] sole [7] hitm [6] mod [3:2] remote delay [1:0] home delay
  input  wire logic [11:0] cfg,
  // Requests from the block
  input  wire logic        core_req, core_snoop_issue, home_req, link_req,
  // Answers
  output logic             llc_hit, llc_sole_owner, core_snoop_hitm,
  output logic             remote_data_valid, remote_data_mod, home_data_valid
);
  // -------------
  // Answer timing
  // -------------
  logic [1:0] rem_q, hom_q;
  // Delay 0 means that agent never answers
  assign remote_data_valid = (rem_q == 2'h1);
  assign home_data_valid   = (hom_q == 2'h1);
  // Outside its valid cycle the flag shows junk, never a held value
  assign remote_data_mod   = remote_data_valid ? cfg[6] : llc_hit;
  // The sibling snoop answers in the cycle of the snoop pulse itself
  assign core_snoop_hitm   = core_snoop_issue ? cfg[7] : ~cfg[7];
  // Lookup answer valid one cycle; toggles every cycle otherwise
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {llc_hit, llc_sole_owner} <= 2'h0;
      rem_q <= 2'h0;
      hom_q <= 2'h0;
    end
    else
    begin
      llc_hit <= core_req ? cfg[9] : ~llc_hit;
      llc_sole_owner <= core_req ? cfg[8] : ~llc_sole_owner;
      rem_q <= link_req ? cfg[3:2] : rem_q - {1'b0, rem_q != 2'h0};
      hom_q <= home_req ? cfg[1:0] : hom_q - {1'b0, hom_q != 2'h0};
    end
  end
endmodule
`default_nettype wire

// File: tb/uncore_coherence_snoop_flow_tb.sv
// Self-checking bench for the snoop flow block.
// Assumes the constants header is on the include path; one clock.
`timescale 1ns/1ps
`default_nettype none
`include "snoop_flow_regs.vh"
module uncore_coherence_snoop_flow_tb;
  // -------
  // Signals
  // -------
  logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        core_req = 1'b0, core_req_rfo = 1'b0, peer_snoop = 1'b0, peer_snoop_rfo = 1'b0, er;
  logic        peer_snoop_local = 1'b0, peer_snoop_from_io = 1'b0, peer_snoop_done = 1'b0;
  logic [11:0] paddr = 12'h000, cfg = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd, nfwd;
  logic [39:0] core_req_addr = 40'h00_0000_0000;
  logic [1:0]  peer_line_state = 2'h0;
  logic [7:0]  seen;
  logic [3:0]  ex;
  int          bad_count = 0, num_checks = 0, cyc = 0;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, llc_hit, llc_sole_owner, core_snoop_hitm, remote_data_valid, remote_data_mod;
  wire logic   home_data_valid, llc_data_return, core_snoop_issue, llc_update, forward_to_core, home_req;
  wire logic   link_req, home_complete, mem_writeback, link_forward, line_invalidate, tracker_full;
  // Rows: {rfo,remote,hit,sole} {hitm,mod,0,0} {remote delay,home delay} then actions expected
  logic [19:0] rows [8] = '{20'h3_0080, 20'h2_0050, 20'h2_8070, 20'h0_0D1C, 20'h0_071E, 20'h0_471F,
                            20'h8_471E, 20'h4_0414};
  logic [7:0]  codes [7] = '{`EV_SNP_LOCAL, `EV_SNP_REMOTE, `EV_LLC_HIT, `EV_LLC_MISS, `EV_OPC_MATCH,
                             `EV_LINES_IN, `EV_LINES_OUT};
  logic [31:0] mv [4] = '{`MATCH_FWD_INV, `MATCH_FWD_SHR, `MATCH_INV_WB, 32'h0000_0000};
  coherence_snoop_flow u_coherence_snoop_flow (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .core_req, .core_req_rfo, .core_req_addr, .llc_hit, .llc_sole_owner, .core_snoop_hitm,
    .remote_data_valid, .remote_data_mod, .home_data_valid, .peer_snoop, .peer_snoop_rfo, .peer_snoop_local,
    .peer_snoop_from_io, .peer_line_state, .peer_snoop_done, .llc_data_return, .core_snoop_issue,
    .llc_update, .forward_to_core, .home_req, .link_req, .home_complete, .mem_writeback, .link_forward,
    .line_invalidate, .tracker_full
  );
  far_side_model u_far_side_model (
    .pclk, .presetn, .cfg, .core_req, .core_snoop_issue, .home_req, .link_req, .llc_hit, .llc_sole_owner,
    .core_snoop_hitm, .remote_data_valid, .remote_data_mod, .home_data_valid
  );
  // -----
  // Tasks
  // -----
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; waits for pready, never assumes a latency
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    // One idle edge so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask
  // Core request; collects eight of the action pulses over the whole flow
  task core(input logic [19:0] r);
    {cfg, core_req_rfo, core_req} <= {r[19:8], r[19], 1'b1};
    core_req_addr <= r[18] ? 40'h00_0000_0040 : 40'h00_0000_0000;
    @(posedge pclk);
    core_req <= 1'b0;
    {seen, nfwd} = 40'h00_0000_0000;
    repeat (12)
    begin
      @(posedge pclk);
      seen = seen | {llc_data_return, core_snoop_issue, llc_update, forward_to_core, home_req, link_req,
                     home_complete, mem_writeback};
      nfwd = nfwd + forward_to_core;
    end
  endtask
  // Peer snoop; optionally retires it afterwards
  task snoop(input logic read_for_ownership, input logic loc, input logic [1:0] st, input logic dn);
    {peer_snoop_rfo, peer_snoop_local, peer_line_state, peer_snoop_from_io, peer_snoop} <= {read_for_ownership, loc, st, st[0], 1'b1};
    @(posedge pclk);
    peer_snoop <= 1'b0;
    seen = 8'h00;
    repeat (4)
    begin
      @(posedge pclk);
      seen = seen | {home_complete, mem_writeback, line_invalidate, link_forward};
    end
    peer_snoop_done <= dn;
    @(posedge pclk);
    peer_snoop_done <= 1'b0;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // -------------------
  // Clock, limit, tests
  // -------------------
  always #12.5 pclk = ~pclk;
  // Whole run needs under a thousand cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, `REG_HOMEBIT, 32'h0000_0006);
    for (int i = 0; i < 8; i++)
    begin
      core(rows[i]);
      chk("core actions", seen, rows[i][7:0]);
      chk("forward count", nfwd, rows[i][4]);
    end
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `REG_MATCH_HI, mv[i]);
      apb(1'b0, `REG_MATCH_HI, 32'h0000_0000);
      chk("match value", rd, mv[i]);
    end
    // Each selection sees one local and one remote snoop, a hit and a miss
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, `REG_EVSEL, {21'h00_0000, i == 4, 2'h0, codes[i]});
      apb(1'b1, `REG_CTRL, 32'h0000_0003);
      snoop(1'b0, 1'b1, `ST_S, 1'b1);
      snoop(1'b0, 1'b0, `ST_S, 1'b1);
      core(rows[0]);
      core(rows[3]);
      apb(1'b0, `REG_COUNT, 32'h0000_0000);
      chk("event count", rd, {31'h0000_0000, i != 4});
      apb(1'b0, `REG_EVSEL, 32'h0000_0000);
      chk("event select", rd[7:0], codes[i]);
    end
    // Hub source, forward-shared match: both shared snoops come from the hub
    apb(1'b1, `REG_MATCH_HI, `MATCH_FWD_SHR);
    apb(1'b1, `REG_EVSEL, {24'h00_0001, `EV_OPC_MATCH});
    apb(1'b1, `REG_CTRL, 32'h0000_0003);
    snoop(1'b0, 1'b1, `ST_S, 1'b1);
    snoop(1'b0, 1'b0, `ST_S, 1'b1);
    apb(1'b0, `REG_COUNT, 32'h0000_0000);
    chk("match count", rd, 32'h0000_0002);
    for (int i = 0; i < 16; i++)
    begin
      snoop(i[3], i[2], i[1:0], 1'b1);
      ex = {i[2] && i[1:0] != 2'h0, i[1:0] == 2'h3 && !i[3], i[3] && i[1:0] != 2'h0, i[1:0] == 2'h3 && !i[3]};
      chk("snoop actions", seen, ex);
    end
    // Fill the tracker, then one more snoop must be dropped
    repeat (12) snoop(1'b0, 1'b1, `ST_S, 1'b0);
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk("tracker busy", rd, 32'h0000_0FFF);
    chk("tracker full", tracker_full, 32'h0000_0001);
    snoop(1'b0, 1'b1, `ST_S, 1'b0);
    chk("refused snoop", seen, 32'h0000_0000);
    // Retire all twelve with no new snoop, else each one refills a slot
    repeat (12)
    begin
      @(posedge pclk);
      peer_snoop_done <= 1'b1;
      @(posedge pclk);
      peer_snoop_done <= 1'b0;
    end
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk("tracker empty", rd, 32'h0000_0000);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk("unmapped data", rd, 32'h0000_0000);
    chk("unmapped error", er, 32'h0000_0001);
    // Clock enable low: a local shared snoop in that time leaves no trace
    clk_en <= 1'b0;
    snoop(1'b0, 1'b1, `ST_S, 1'b1);
    chk("frozen snoop", seen, 32'h0000_0000);
    clk_en <= 1'b1;
    // Mid-run reset restores written registers
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("reset outputs", {home_req, link_req, home_complete, forward_to_core, pready}, 32'h0000_0000);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `REG_HOMEBIT, 32'h0000_0000);
    chk("home bit reset", rd, `HOMEBIT_RESET);
    apb(1'b0, `REG_EVSEL, 32'h0000_0000);
    chk("select reset", rd, `EVSEL_RESET);
    end_of_test();
  end
endmodule
`default_nettype wire
